// ---- src/amx_consts.vh ----
`ifndef AMX_CONSTS_VH
`define AMX_CONSTS_VH
// channel count and select width
`define AMX_NUM_CH 24
`define AMX_SEL_W 5
// select codes
`define AMX_SEL_HIZ 5'h00
`define AMX_SEL_FIRST 5'h01
`define AMX_SEL_LAST 5'h18
// output modes
`define AMX_MODE_PULLDN 3'h1
`define AMX_MODE_HIZ 3'h2
`define AMX_MODE_DRIVE 3'h4
// reset values
`define AMX_RST_SEL 5'h00
`define AMX_RST_EN 1'h0
`define AMX_RST_STATE 3'h1
// channel bit positions by group
`define AMX_BIT_SUPPLY_LO 0
`define AMX_BIT_SUPPLY_HI 2
`define AMX_BIT_SWFB_LO 3
`define AMX_BIT_SWFB_HI 9
`define AMX_BIT_LINREG_LO 10
`define AMX_BIT_LINREG_HI 13
`define AMX_BIT_DIETEMP 14
`define AMX_BIT_REGTEMP_LO 15
`define AMX_BIT_REGTEMP_HI 23
// output state bits
`define AMX_MODE_BIT_PULLDN 0
`define AMX_MODE_BIT_HIZ 1
`define AMX_MODE_BIT_DRIVE 2
`endif

// ---- src/amx_decode.v ----
`timescale 1ns/1ns
`include "amx_consts.vh"
module amx_decode #(
    parameter NUM_CH = `AMX_NUM_CH
) (
    // control
    input wire enable_in,
    input wire sys_on_in,
    input wire [`AMX_SEL_W-1:0] sel_in,
    // decoded
    output wire [NUM_CH-1:0] onehot_out,
    output wire [2:0] mode_out
);
    wire any_w;
    genvar i;
    // one-hot decode, one line per routed channel
    generate
        for (i = 0; i < NUM_CH; i = i + 1) begin : g_ch
            localparam [`AMX_SEL_W-1:0] CODE = i + 1;
            assign onehot_out[i] = enable_in && sys_on_in &&
                (sel_in == CODE);
        end
    endgenerate
    // codes 1..24 route channels, above that none
    assign any_w = |onehot_out;
    assign mode_out = !(enable_in && sys_on_in) ? `AMX_MODE_PULLDN :
        (any_w ? `AMX_MODE_DRIVE : `AMX_MODE_HIZ);
endmodule

// ---- src/amx_mux_ctrl.v ----
`timescale 1ns/1ns
`include "amx_consts.vh"
// Notes on behaviour
// - 24 channels; output driven only in system-on states.
// - enable low: mux off, output pulled to ground, select ignored.
// - enable high: channel chosen from 5-bit select field.
// - enable high, select zero: no channel, output high impedance.
// - codes 1-3: input supply, backup supply, coin cell.
// - codes 4-9 switcher 1-6 feedback; code 10 switcher 7.
// - codes 11-14: linear regulator 1-4 outputs.
// - 15 die temp; 16-24 regional sensors; 25-31 reserved.
module amx_mux_ctrl #(
    parameter NUM_CH = `AMX_NUM_CH
) (
    // clock and reset
    input wire mclk_in,
    input wire reset_in,

    // control from register logic, same clock
    input wire monitor_enable_in,
    input wire [`AMX_SEL_W-1:0] monitor_channel_select_in,
    input wire sys_on_in,

    // analog switch controls
    output wire [NUM_CH-1:0] channel_route_out,
    output wire pulldown_out,
    output wire buffer_drive_out,
    output wire hiz_out
);

    ////////////////////////////////////////////////////////////////////
    // output states, one-hot
    localparam [2:0] ST_PULLDN = `AMX_MODE_PULLDN;
    localparam [2:0] ST_HIZ = `AMX_MODE_HIZ;
    localparam [2:0] ST_DRIVE = `AMX_MODE_DRIVE;

    ////////////////////////////////////////////////////////////////////
    // decoder results
    wire [NUM_CH-1:0] onehot_w;
    wire [2:0] mode_w;
    wire active_w;
    wire reserved_w;

    ////////////////////////////////////////////////////////////////////
    // group hits
    wire supply_hit_w;
    wire swfb_hit_w;
    wire linreg_hit_w;
    wire dietemp_hit_w;
    wire regtemp_hit_w;
    wire group_hit_w;
    wire [NUM_CH-1:0] legal_w;

    ////////////////////////////////////////////////////////////////////
    // state and routing
    reg [2:0] state_r;
    reg [2:0] state_nxt;
    reg [NUM_CH-1:0] route_r;
    wire [NUM_CH-1:0] route_nxt;
    wire drive_nxt;
    genvar k;

    ////////////////////////////////////////////////////////////////////
    // decode
    amx_decode #(
        .NUM_CH(NUM_CH)
    ) u_dec (
        .enable_in(monitor_enable_in),
        .sys_on_in(sys_on_in),
        .sel_in(monitor_channel_select_in),
        .onehot_out(onehot_w),
        .mode_out(mode_w)
    );

    ////////////////////////////////////////////////////////////////////
    // mux runs only when enabled and system on
    assign active_w = monitor_enable_in && sys_on_in;

    ////////////////////////////////////////////////////////////////////
    // codes above the last channel route nothing
    assign reserved_w = active_w &&
        (monitor_channel_select_in > `AMX_SEL_LAST);

    ////////////////////////////////////////////////////////////////////
    // input supply, backup supply, coin cell
    assign supply_hit_w =
        |onehot_w[`AMX_BIT_SUPPLY_HI:`AMX_BIT_SUPPLY_LO];

    ////////////////////////////////////////////////////////////////////
    // switcher feedback, switchers one to seven
    assign swfb_hit_w =
        |onehot_w[`AMX_BIT_SWFB_HI:`AMX_BIT_SWFB_LO];

    ////////////////////////////////////////////////////////////////////
    // linear regulator outputs
    assign linreg_hit_w =
        |onehot_w[`AMX_BIT_LINREG_HI:`AMX_BIT_LINREG_LO];

    ////////////////////////////////////////////////////////////////////
    // die centre sensor
    assign dietemp_hit_w = onehot_w[`AMX_BIT_DIETEMP];

    ////////////////////////////////////////////////////////////////////
    // regional sensors
    assign regtemp_hit_w =
        |onehot_w[`AMX_BIT_REGTEMP_HI:`AMX_BIT_REGTEMP_LO];

    ////////////////////////////////////////////////////////////////////
    // any routable channel
    assign group_hit_w = supply_hit_w || swfb_hit_w || linreg_hit_w ||
        dietemp_hit_w || regtemp_hit_w;

    ////////////////////////////////////////////////////////////////////
    // channel group membership
    generate
        for (k = 0; k < NUM_CH; k = k + 1) begin : g_legal
            if (k <= `AMX_BIT_SUPPLY_HI) begin : g_sup
                assign legal_w[k] = supply_hit_w;
            end else if (k <= `AMX_BIT_SWFB_HI) begin : g_fb
                assign legal_w[k] = swfb_hit_w;
            end else if (k <= `AMX_BIT_LINREG_HI) begin : g_lin
                assign legal_w[k] = linreg_hit_w;
            end else if (k == `AMX_BIT_DIETEMP) begin : g_die
                assign legal_w[k] = dietemp_hit_w;
            end else begin : g_reg
                assign legal_w[k] = regtemp_hit_w;
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // next output state
    always @* begin
        state_nxt = ST_PULLDN;
        case (mode_w)
            ST_PULLDN: begin
                state_nxt = ST_PULLDN;
            end

            ST_HIZ: begin
                if (active_w) begin
                    state_nxt = ST_HIZ;
                end else begin
                    state_nxt = ST_PULLDN;
                end
            end

            ST_DRIVE: begin
                if (active_w && group_hit_w && !reserved_w) begin
                    state_nxt = ST_DRIVE;
                end else if (active_w) begin
                    state_nxt = ST_HIZ;
                end else begin
                    state_nxt = ST_PULLDN;
                end
            end

            default: begin
                state_nxt = ST_PULLDN;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // a channel is routed only in the drive state
    assign drive_nxt = state_nxt[`AMX_MODE_BIT_DRIVE];

    generate
        for (k = 0; k < NUM_CH; k = k + 1) begin : g_route
            assign route_nxt[k] = onehot_w[k] && legal_w[k] &&
                drive_nxt;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // state register, pulled down from reset
    always @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            state_r <= `AMX_RST_STATE;
        end else begin
            state_r <= state_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // route register, nothing routed from reset
    always @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            route_r <= {NUM_CH{1'b0}};
        end else begin
            route_r <= route_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs straight from flops
    assign channel_route_out = route_r;
    assign pulldown_out = state_r[`AMX_MODE_BIT_PULLDN];
    assign hiz_out = state_r[`AMX_MODE_BIT_HIZ];
    assign buffer_drive_out = state_r[`AMX_MODE_BIT_DRIVE];

endmodule

// ---- verif/amx_chk.sv ----
`timescale 1ns/1ns
module amx_chk (
    // clock and reset
    input wire mclk_in,
    input wire reset_in,
    // controls
    input wire monitor_enable_in,
    input wire sys_on_in,
    input wire [4:0] monitor_channel_select_in,
    // outputs under check
    input wire [23:0] channel_route_out,
    input wire pulldown_out,
    input wire buffer_drive_out,
    input wire hiz_out
);
    wire on_w;
    wire none_w;
    wire [4:0] sel_w;
    assign on_w = monitor_enable_in && sys_on_in;
    assign none_w = (channel_route_out == 24'h000000);
    assign sel_w = monitor_channel_select_in;
    default clocking @(posedge mclk_in); endclocking
    default disable iff (reset_in);
    ////////////////////////////////////////////////////////////////////
    // request steps
    sequence s_off;
        !on_w;
    endsequence
    sequence s_idle_code;
        on_w && (sel_w == 5'h00 || sel_w > 5'h18);
    endsequence
    sequence s_live_code;
        on_w && sel_w != 5'h00 && sel_w <= 5'h18;
    endsequence
    ////////////////////////////////////////////////////////////////////
    // properties
    a_off_pd: assert property (s_off |=> pulldown_out && none_w)
        else $error("output not pulled down while off");
    a_idle_hiz: assert property (s_idle_code |=> hiz_out && none_w)
        else $error("output not high impedance for idle code");
    a_code_route: assert property (s_live_code |=> buffer_drive_out &&
        channel_route_out == (24'h000001 << ($past(sel_w) - 5'h01)))
        else $error("wrong channel routed");
    a_one_state: assert property ($onehot({pulldown_out, hiz_out,
        buffer_drive_out}))
        else $error("output state not exactly one");
    a_sysoff_pd: assert property (!sys_on_in |=> pulldown_out &&
        !buffer_drive_out && none_w)
        else $error("output active outside system on");
    a_route_onehot: assert property ($onehot0(channel_route_out))
        else $error("more than one channel routed");
    a_change_direct: assert property (s_live_code ##0 $changed(sel_w)
        |=> $changed(channel_route_out))
        else $error("routing did not follow select change");
endmodule
bind amx_mux_ctrl amx_chk u_chk (.*);

// ---- verif/analog_mux_channel_select_bench.sv ----
`timescale 1ns/1ns
module analog_mux_channel_select_bench;
    // run length limit, cycles
    localparam integer TIMEOUT = 1000;
    // clock and reset
    reg mclk_in = 1'b0;
    reg reset_in = 1'b1;
    // stimulus
    reg enable_r = 1'b0;
    reg sys_on_r = 1'b0;
    reg [4:0] sel_r = 5'h00;
    reg [4:0] lfsr_r = 5'h0b;
    reg [26:0] expect_r;
    // observed
    wire [23:0] route_w;
    wire pulldown_w;
    wire drive_w;
    wire hiz_w;
    integer n_errors = 0;
    integer samples_checked = 0;
    integer cycles = 0;
    integer i;
    ////////////////////////////////////////////////////////////////////
    // design under test
    amx_mux_ctrl dut (
        .mclk_in(mclk_in),
        .reset_in(reset_in),
        .monitor_enable_in(enable_r),
        .monitor_channel_select_in(sel_r),
        .sys_on_in(sys_on_r),
        .channel_route_out(route_w),
        .pulldown_out(pulldown_w),
        .buffer_drive_out(drive_w),
        .hiz_out(hiz_w)
    );
    ////////////////////////////////////////////////////////////////////
    // clock and run limit
    always #5 mclk_in = ~mclk_in;
    always @(posedge mclk_in) begin
        cycles = cycles + 1;
        if (cycles > TIMEOUT) begin
            n_errors = n_errors + 1;
            summarize;
        end
    end
    ////////////////////////////////////////////////////////////////////
    // expected {drive, hiz, pulldown, route}
    function [26:0] expect_of;
        input en;
        input on;
        input [4:0] sel;
        begin
            if (!(en && on)) begin
                expect_of = 27'h1000000;
            end else if (sel == 5'h00 || sel > 5'h18) begin
                expect_of = 27'h2000000;
            end else begin
                expect_of = 27'h4000000 | (27'h0000001 << (sel - 5'h01));
            end
        end
    endfunction
    function [4:0] lfsr_next;
        input [4:0] v;
        begin
            lfsr_next = {v[3:0], v[4] ^ v[2]};
        end
    endfunction
    ////////////////////////////////////////////////////////////////////
    // compare and report
    task check;
        input [26:0] seen;
        input [26:0] want;
        begin
            samples_checked = samples_checked + 1;
            if (seen !== want) begin
                n_errors = n_errors + 1;
                $display("[ERR] %0t %h %h", $time, seen, want);
            end
        end
    endtask
    task summarize;
        begin
            $display("errors %0d checks %0d", n_errors, samples_checked);
            if (n_errors == 0 && samples_checked > 0) begin
                $display("Simulation passed");
            end else begin
                $display("Simulation failed");
            end
            $finish;
        end
    endtask
    ////////////////////////////////////////////////////////////////////
    // sweep, random, then corner cases
    initial begin
        repeat (5) @(posedge mclk_in);
        reset_in <= 1'b0;
        for (i = 0; i < 306; i = i + 1) begin
            @(posedge mclk_in);
            expect_r = expect_of(enable_r, sys_on_r, sel_r);
            lfsr_r = lfsr_next(lfsr_r);
            if (i >= 300) begin
                enable_r <= (i != 300);
                sys_on_r <= (i != 301);
                sel_r <= (i < 304) ? 5'h03 : (i == 304 ? 5'h19 : 5'h1f);
            end else begin
                enable_r <= (i < 32) || lfsr_r[0];
                sys_on_r <= (i < 32) || lfsr_r[1] || lfsr_r[2];
                sel_r <= (i < 32) ? i[4:0] : lfsr_r;
            end
            #1 check({drive_w, hiz_w, pulldown_w, route_w}, expect_r);
        end
        @(posedge mclk_in);
        #1 check({drive_w, hiz_w, pulldown_w, route_w},
            expect_of(enable_r, sys_on_r, sel_r));
        summarize;
    end
endmodule
